// >>> usc_map.svh
// Register offsets, field positions, reset values and counts of the USART core.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one register per word.
`ifndef USC_MAP_SVH
`define USC_MAP_SVH
// Register byte offsets
`define USC_OFS_DATA 8'h00
`define USC_OFS_CSA 8'h04
`define USC_OFS_CSB 8'h08
`define USC_OFS_CSC 8'h0C
`define USC_OFS_BDL 8'h10
`define USC_OFS_BDH 8'h14
`define USC_OFS_PDIR 8'h18
// Control and status A fields
`define USC_CSA_RXC 7
`define USC_CSA_TXC 6
`define USC_CSA_DRE 5
`define USC_CSA_FE 4
`define USC_CSA_DOR 3
`define USC_CSA_PE 2
`define USC_CSA_DSPEED 1
// Control B fields
`define USC_CSB_RXCIE 7
`define USC_CSB_TXCIE 6
`define USC_CSB_DREIE 5
`define USC_CSB_RXEN 4
`define USC_CSB_TXEN 3
`define USC_CSB_SIZE2 2
`define USC_CSB_RX9 1
`define USC_CSB_TX9 0
// Control and status C fields
`define USC_CSC_MODE 6
`define USC_CSC_PM_HI 5
`define USC_CSC_PM_LO 4
`define USC_CSC_STOP2 3
`define USC_CSC_SZ_HI 2
`define USC_CSC_SZ_LO 1
`define USC_CSC_POL 0
// Reset values
`define USC_CSB_RST 8'h00
`define USC_CSC_RST 8'h06
`define USC_DIV_RST 12'h000
// Samples per bit and transmit divider last counts
`define USC_OS_NORMAL 5'h10
`define USC_OS_DOUBLE 5'h08
`define USC_TXDIV_NORMAL 4'hF
`define USC_TXDIV_DOUBLE 4'h7
// Bus responses
`define USC_RESP_OKAY 2'h0
`define USC_RESP_SLVERR 2'h2
`endif

// >>> usc_pkg.sv
// Types shared by the USART core, its clock generator and its receive FIFO.
// Assumes usc_map.svh supplies all numeric constants.
package usc_pkg;
  // AXI4-Lite request from the master
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } usc_axi_req_type;
  // AXI4-Lite answer from this slave
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } usc_axi_rsp_type;
  // Clock generator settings
  typedef struct packed {
    logic [11:0] div;
    logic div_load;
    logic dspeed;
    logic sync_mode;
    logic pin_dir;
    logic pol;
  } usc_clkcfg_type;
  // One received character with its status
  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic data_overrun_flag;
    logic pe;
  } usc_rxent_type;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} usc_txst_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} usc_rxst_type;
endpackage

// >>> usc_clkgen.sv
// Baud generator, transmit divider and sync clock pin handling.
// Assumes configuration comes from registers in the same clock domain.
`timescale 1ns/1ps
`include "usc_map.svh"
module usc_clkgen
  import usc_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Settings
  input wire usc_clkcfg_type cfg,
  // Sync clock pin
  input wire logic sync_clock_pin_i,
  output logic sync_clock_pin_o,
  output logic sync_clock_pin_oe,
  // Bit strobes
  output logic tx_tick,
  output logic rx_tick
);
  typedef struct packed {
    logic [11:0] cnt;
    logic [3:0] txdiv;
    logic sync_clock_pin;
    logic s1;
    logic s2;
    logic s3;
  } usc_clkst_type;
  usc_clkst_type q, d;
  logic baud, master, rise, fall, change, sample, async_tx;
  logic [3:0] last;

  // Next state and strobes
  always_comb
  begin
    d = q;
    baud = clk_en && (q.cnt == 12'h000);
    // Reload on zero or low divisor write
    d.cnt = (q.cnt == 12'h000 || cfg.div_load) ? cfg.div : q.cnt - 12'h001;
    // Master when the pin drives out in sync mode
    master = cfg.sync_mode && cfg.pin_dir;
    if (baud && master)
      d.sync_clock_pin = ~q.sync_clock_pin;
    // First stage feeds only the second stage
    d.s1 = sync_clock_pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    rise = master ? (baud && !q.sync_clock_pin) : (clk_en && q.s2 && !q.s3);
    fall = master ? (baud && q.sync_clock_pin) : (clk_en && !q.s2 && q.s3);
    // Polarity picks change and sample edges
    change = cfg.pol ? fall : rise;
    sample = cfg.pol ? rise : fall;
    // Double speed only in async mode
    last = cfg.dspeed ? `USC_TXDIV_DOUBLE : `USC_TXDIV_NORMAL;
    async_tx = baud && (q.txdiv == last);
    if (baud)
      d.txdiv = async_tx ? 4'h0 : q.txdiv + 4'h1;
    // Master halves the baud output, slave uses pin edges
    tx_tick = cfg.sync_mode ? change : async_tx;
    rx_tick = cfg.sync_mode ? sample : baud;
  end

  // Pin is idle outside sync mode
  assign sync_clock_pin_o = q.sync_clock_pin;
  assign sync_clock_pin_oe = master;

  // State register
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '0;
    else if (clk_en)
      q <= d;
  end
endmodule

// >>> usc_rxfifo.sv
// Circular receive FIFO holding characters with their status bits.
// Assumes push is only asserted while not full.
`timescale 1ns/1ps
module usc_rxfifo
  import usc_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Write side
  input wire logic push,
  input wire usc_rxent_type push_ent,
  output logic full,
  // Read side
  input wire logic pop,
  output usc_rxent_type head,
  output logic not_empty
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    usc_rxent_type [DEPTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } usc_fifost_type;
  usc_fifost_type q, d;
  logic do_push, do_pop;

  // Pointers wrap at DEPTH; status stays with each entry
  always_comb
  begin
    d = q;
    do_push = push && !full;
    do_pop = pop && not_empty;
    if (do_push)
    begin
      d.mem[q.wp] = push_ent;
      d.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + PW'(1);
    end
    if (do_pop)
      d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + PW'(1);
    d.cnt = q.cnt + CW'(do_push) - CW'(do_pop);
  end

  assign full = (q.cnt == CW'(DEPTH));
  assign not_empty = (q.cnt != '0);
  assign head = q.mem[q.rp];

  // State register
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '0;
    else if (clk_en)
      q <= d;
  end
endmodule

// >>> usc_core.sv
// USART core: AXI4-Lite registers, transmitter, receiver with third level.
// Assumes rxd and the sync clock pin arrive already in this domain's timing
// sense; the sync pin still passes a two-stage synchroniser.
//
// Overview of operation
// - Two-entry receive FIFO, a data read pops one if not empty
// - Frame error, overrun, ninth bit stored per entry
// - Shift register holds third character; overrun on start
// - Four clock modes, mode select picks sync
// - Double speed only acts in async mode
// - Pin direction picks master or slave clock
// - Down-counter reloads at zero or low write
// - Transmit divides baud by 16, 8 or 2
// - Receiver samples 16, 8 or 1 per bit
// - Divisor is twelve bits from high and low
// - Slave clock synchronised and edge detected, two cycles
// - Sample on edge opposite to data change
// - Polarity bit selects change and sample edges
// - Frames: 5-9 data, parity option, 1-2 stops
// - Start, data LSB first, parity, then stops
// - After stop, next frame or idle high
// - Three interrupts: tx complete, empty, rx complete
// - Parity is xor of data, inverted for odd
// - Only first stop bit checked for frame error
// - Buffer loads shifter when idle or after stop
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "usc_map.svh"
module usc_core
  import usc_pkg::*;
#(
  parameter int RX_DEPTH = 2
)
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register bus
  input wire usc_axi_req_type axi_req,
  output usc_axi_rsp_type axi_rsp,
  // Serial lines
  input wire logic rxd_in,
  output logic txd_out,
  // Sync clock pin
  input wire logic sync_clock_pin_i,
  output logic sync_clock_pin_o,
  output logic sync_clock_pin_oe,
  // Interrupt sources
  output logic irq_rx_complete,
  output logic irq_tx_complete,
  output logic irq_data_empty
);
  typedef struct packed {
    // Bus
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // Configuration
    logic [7:0] csb;
    logic [7:0] csc;
    logic dspeed;
    logic [11:0] div;
    logic pdir;
    logic txc;
    // Transmitter
    usc_txst_type tst;
    logic [8:0] tbuf;
    logic tbufv;
    logic [8:0] tsh;
    logic [3:0] tbc;
    logic tpar;
    logic tsb;
    logic txd;
    // Receiver
    usc_rxst_type rst;
    logic [4:0] rsc;
    logic [3:0] rbc;
    logic [8:0] rsh;
    logic rpar;
    logic rpe;
    logic hold;
    usc_rxent_type hent;
    logic ovr_pend;
  } usc_corest_type;
  usc_corest_type q, d;

  usc_clkcfg_type cfg;
  usc_rxent_type head, pent;
  logic tx_tick, rx_tick, full, not_empty, push, pop;
  logic do_wr, do_rd, wr_ok, rd_ok, rx_bit, done;
  logic [2:0] size;
  logic [3:0] nbits;
  logic [4:0] nsamp;
  logic [8:0] aligned;
  logic [31:0] rval;

  // Clock settings seen by the generator
  always_comb
  begin
    cfg.div = q.div;
    cfg.div_load = do_wr && (q.awaddr == `USC_OFS_BDL) && q.wstrb[0];
    cfg.dspeed = q.dspeed;
    cfg.sync_mode = q.csc[`USC_CSC_MODE];
    cfg.pin_dir = q.pdir;
    cfg.pol = q.csc[`USC_CSC_POL];
  end

  usc_clkgen u_clkgen (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .cfg(cfg),
    .sync_clock_pin_i(sync_clock_pin_i),
    .sync_clock_pin_o(sync_clock_pin_o),
    .sync_clock_pin_oe(sync_clock_pin_oe),
    .tx_tick(tx_tick),
    .rx_tick(rx_tick)
  );

  usc_rxfifo #(
    .DEPTH(RX_DEPTH)
  ) u_rxfifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .push(push),
    .push_ent(pent),
    .full(full),
    .pop(pop),
    .head(head),
    .not_empty(not_empty)
  );

  // Frame format decode; reserved sizes fall back to eight bits
  always_comb
  begin
    size = {q.csb[`USC_CSB_SIZE2], q.csc[`USC_CSC_SZ_HI:`USC_CSC_SZ_LO]};
    if (size == 3'h7)
      nbits = 4'h9;
    else if (size <= 3'h3)
      nbits = {1'b0, size} + 4'h5;
    else
      nbits = 4'h8;
    // Async samples per bit; sync takes one sample per clock
    nsamp = q.dspeed ? `USC_OS_DOUBLE : `USC_OS_NORMAL;
    aligned = q.rsh >> (4'h9 - nbits);
  end

  // Bus handshakes: one write and one read in flight
  assign axi_rsp.awready = !q.aw_got && !q.bvalid;
  assign axi_rsp.wready = !q.w_got && !q.bvalid;
  assign axi_rsp.arready = !q.rvalid;
  assign axi_rsp.bvalid = q.bvalid;
  assign axi_rsp.bresp = q.bresp;
  assign axi_rsp.rvalid = q.rvalid;
  assign axi_rsp.rdata = q.rdata;
  assign axi_rsp.rresp = q.rresp;
  assign do_wr = q.aw_got && q.w_got && !q.bvalid;
  assign do_rd = axi_req.arvalid && !q.rvalid;
  assign wr_ok = (q.awaddr[1:0] == 2'h0) && (q.awaddr <= `USC_OFS_PDIR);
  assign rd_ok = (axi_req.araddr[1:0] == 2'h0) && (axi_req.araddr <= `USC_OFS_PDIR);
  // Each data read takes one entry, none when the FIFO is empty
  assign pop = do_rd && (axi_req.araddr == `USC_OFS_DATA);

  // Read data; status reflects the entry at the FIFO head
  always_comb
  begin
    rval = 32'h0000_0000;
    unique case (axi_req.araddr)
      `USC_OFS_DATA: rval[7:0] = not_empty ? head.data[7:0] : 8'h00;
      `USC_OFS_CSA:
      begin
        rval[`USC_CSA_RXC] = not_empty;
        rval[`USC_CSA_TXC] = q.txc;
        rval[`USC_CSA_DRE] = !q.tbufv;
        rval[`USC_CSA_FE] = not_empty && head.fe;
        rval[`USC_CSA_DOR] = not_empty && head.data_overrun_flag;
        rval[`USC_CSA_PE] = not_empty && head.pe;
        rval[`USC_CSA_DSPEED] = q.dspeed;
      end
      `USC_OFS_CSB:
      begin
        rval[7:0] = q.csb;
        rval[`USC_CSB_RX9] = not_empty && head.data[8];
      end
      `USC_OFS_CSC: rval[7:0] = q.csc;
      `USC_OFS_BDL: rval[7:0] = q.div[7:0];
      `USC_OFS_BDH: rval[3:0] = q.div[11:8];
      `USC_OFS_PDIR: rval[0] = q.pdir;
      default: rval = 32'h0000_0000;
    endcase
  end

  // Receive push: a fresh frame, or the held third-level character
  always_comb
  begin
    // Bit strobe first: done must not see last evaluation's value
    rx_bit = rx_tick && (q.csc[`USC_CSC_MODE] || q.rsc == nsamp - 5'h01);
    done = (q.rst == RX_STOP) && rx_bit;
    pent.data = aligned;
    // First stop bit alone decides the frame error
    pent.fe = !rxd_in;
    pent.data_overrun_flag = q.ovr_pend;
    pent.pe = q.rpe;
    if (!done)
      pent = q.hent;
    push = (done || q.hold) && !full;
  end

  // Whole block next state
  always_comb
  begin
    d = q;
    // Write address and data may arrive in either order
    if (axi_req.awvalid && axi_rsp.awready)
    begin
      d.aw_got = 1'b1;
      d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready)
    begin
      d.w_got = 1'b1;
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
    end
    if (q.bvalid && axi_req.bready)
      d.bvalid = 1'b0;
    if (do_wr)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_ok ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
      if (q.wstrb[0])
      begin
        unique case (q.awaddr)
          `USC_OFS_DATA:
          begin
            // A write into a full buffer is dropped
            if (!q.tbufv)
            begin
              d.tbuf = {q.csb[`USC_CSB_TX9], q.wdata[7:0]};
              d.tbufv = 1'b1;
            end
          end
          `USC_OFS_CSA:
          begin
            d.dspeed = q.wdata[`USC_CSA_DSPEED];
            if (q.wdata[`USC_CSA_TXC])
              d.txc = 1'b0;
          end
          `USC_OFS_CSB:
          begin
            d.csb = q.wdata[7:0];
            d.csb[`USC_CSB_RX9] = 1'b0;
          end
          `USC_OFS_CSC: d.csc = q.wdata[7:0];
          // Divisor halves form one twelve-bit value
          `USC_OFS_BDL: d.div[7:0] = q.wdata[7:0];
          `USC_OFS_BDH: d.div[11:8] = q.wdata[3:0];
          `USC_OFS_PDIR: d.pdir = q.wdata[0];
          default: d.bresp = `USC_RESP_SLVERR;
        endcase
      end
    end
    if (q.rvalid && axi_req.rready)
      d.rvalid = 1'b0;
    if (do_rd)
    begin
      d.rvalid = 1'b1;
      d.rdata = rval;
      d.rresp = rd_ok ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
    end

    // Transmitter advances one bit per tick
    if (!q.csb[`USC_CSB_TXEN])
    begin
      d.tst = TX_IDLE;
      d.txd = 1'b1;
    end
    else if (tx_tick)
    begin
      unique case (q.tst)
        TX_IDLE:
        begin
          // Idle shifter takes the buffer on the next tick
          if (q.tbufv)
          begin
            d.tsh = q.tbuf;
            d.tbufv = 1'b0;
            d.txd = 1'b0;
            d.tst = TX_START;
          end
        end
        TX_START:
        begin
          d.txd = q.tsh[0];
          d.tpar = q.tsh[0];
          d.tsh = q.tsh >> 1;
          d.tbc = 4'h1;
          d.tst = TX_DATA;
        end
        TX_DATA:
        begin
          if (q.tbc < nbits)
          begin
            d.txd = q.tsh[0];
            d.tpar = q.tpar ^ q.tsh[0];
            d.tsh = q.tsh >> 1;
            d.tbc = q.tbc + 4'h1;
          end
          else if (q.csc[`USC_CSC_PM_HI])
          begin
            // Even parity is the xor, odd its inverse
            d.txd = q.tpar ^ q.csc[`USC_CSC_PM_LO];
            d.tst = TX_PAR;
          end
          else
          begin
            d.txd = 1'b1;
            d.tsb = 1'b0;
            d.tst = TX_STOP;
          end
        end
        TX_PAR:
        begin
          d.txd = 1'b1;
          d.tsb = 1'b0;
          d.tst = TX_STOP;
        end
        TX_STOP:
        begin
          if (q.csc[`USC_CSC_STOP2] && !q.tsb)
            d.tsb = 1'b1;
          else if (q.tbufv)
          begin
            // Back-to-back frame straight after the last stop
            d.tsh = q.tbuf;
            d.tbufv = 1'b0;
            d.txd = 1'b0;
            d.tst = TX_START;
          end
          else
          begin
            // Line rests high; frame complete
            d.txd = 1'b1;
            d.txc = 1'b1;
            d.tst = TX_IDLE;
          end
        end
      endcase
    end

    // Receiver sampling; sync mode samples once on the sample edge
    if (rx_tick)
      d.rsc = (rx_bit || q.rst == RX_IDLE) ? 5'h00 : q.rsc + 5'h01;
    if (!q.csb[`USC_CSB_RXEN])
      d.rst = RX_IDLE;
    else if (rx_tick)
    begin
      unique case (q.rst)
        RX_IDLE:
        begin
          if (!rxd_in)
          begin
            // New start while a character is held loses it
            if (q.hold && full)
            begin
              d.hold = 1'b0;
              d.ovr_pend = 1'b1;
            end
            d.rbc = 4'h0;
            d.rpar = q.csc[`USC_CSC_PM_LO];
            d.rst = q.csc[`USC_CSC_MODE] ? RX_DATA : RX_START;
          end
        end
        RX_START:
        begin
          // Mid-bit check rejects a false start
          if (q.rsc == (nsamp >> 1) - 5'h01)
          begin
            d.rsc = 5'h00;
            d.rst = rxd_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (rx_bit)
          begin
            d.rsh = {rxd_in, q.rsh[8:1]};
            d.rpar = q.rpar ^ rxd_in;
            d.rbc = q.rbc + 4'h1;
            if (q.rbc + 4'h1 == nbits)
              d.rst = q.csc[`USC_CSC_PM_HI] ? RX_PAR : RX_STOP;
            d.rpe = 1'b0;
          end
        end
        RX_PAR:
        begin
          if (rx_bit)
          begin
            d.rpe = q.rpar ^ rxd_in;
            d.rst = RX_STOP;
          end
        end
        RX_STOP:
        begin
          // Second stop bit is never looked at
          if (rx_bit)
            d.rst = RX_IDLE;
        end
      endcase
    end
    // FIFO full: keep the finished character in the shifter
    if (done && full)
    begin
      d.hold = 1'b1;
      d.hent = pent;
      d.ovr_pend = 1'b0;
    end
    if (push)
    begin
      if (!done)
        d.hold = 1'b0;
      else
        d.ovr_pend = 1'b0;
    end
    // Completion sets even against a clearing write
    if (q.csb[`USC_CSB_TXEN] && tx_tick && q.tst == TX_STOP && !d.tbufv && d.tst == TX_IDLE)
      d.txc = 1'b1;
  end

  // Interrupt sources, each gated by its enable
  assign irq_rx_complete = q.csb[`USC_CSB_RXCIE] && not_empty;
  assign irq_tx_complete = q.csb[`USC_CSB_TXCIE] && q.txc;
  assign irq_data_empty = q.csb[`USC_CSB_DREIE] && !q.tbufv;
  assign txd_out = q.txd;

  // State register; reset leaves the line idle high
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.csb <= `USC_CSB_RST;
      q.csc <= `USC_CSC_RST;
      q.div <= `USC_DIV_RST;
      q.txd <= 1'b1;
    end
    else if (clk_en)
      q <= d;
  end
endmodule

// >>> usc_chk.sv
// Checker of the USART core ports: bus answers, line idle level, pin enable.
// Assumes one clock domain; bound to every usc_core instance.
`timescale 1ns/1ps
module usc_chk
  import usc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register bus
  input wire usc_axi_req_type axi_req,
  input wire usc_axi_rsp_type axi_rsp,
  // Pins
  input wire logic txd_out,
  input wire logic sync_clock_pin_o,
  input wire logic sync_clock_pin_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Line must rest high after reset, or the peer sees a false start
  AST_TXD_IDLE: assert property ($fell(sys_rst) |-> txd_out && !sync_clock_pin_oe)
    else $error("line or pin enable wrong after reset");
  // A start or data bit lasts at least two cycles in every mode
  AST_START_LEN: assert property ($fell(txd_out) |=> !txd_out)
    else $error("bit shorter than two cycles");
  // Pin clock stays still unless the device drives the pin
  AST_PIN_QUIET: assert property (!sync_clock_pin_oe |=> $stable(sync_clock_pin_o))
    else $error("pin clock moved while not driven");
  AST_RD_ANSWER: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read not answered");
  // Read data must not change while waiting, or a pop would be lost
  AST_RD_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read answer dropped");
  AST_NO_DOUBLE_RD: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("second read taken");
  AST_ERR_ZERO: assert property (axi_rsp.rvalid && axi_rsp.rresp == 2'h2 |->
    axi_rsp.rdata == 32'h0)
    else $error("refused read returned data");
  AST_WR_ANSWER: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid &&
    axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid)
    else $error("write not answered");
  AST_B_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write answer dropped");
endmodule
bind usc_core usc_chk usc_chk_i (.core_clk(core_clk), .sys_rst(sys_rst), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .txd_out(txd_out), .sync_clock_pin_o(sync_clock_pin_o),
  .sync_clock_pin_oe(sync_clock_pin_oe));

// >>> usc_peer.sv
// Remote serial transceiver: sends frames on the receive line, captures transmit frames.
// Assumes async mode; bit time given in core clock cycles by the caller.
`timescale 1ns/1ps
module usc_peer
(
  // Clock and line from the device
  input wire logic core_clk,
  input wire logic txd_out,
  // Line to the device, idle high
  output logic rxd_in
);
  initial rxd_in = 1'b1;
  // Start, eight data bits LSB first, stop, then one idle bit
  task automatic send(input logic [7:0] d, input int bt, input logic stp);
    @(posedge core_clk);
    rxd_in <= 1'b0;
    repeat (bt) @(posedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      rxd_in <= d[i];
      repeat (bt) @(posedge core_clk);
    end
    rxd_in <= stp;
    // A bad stop is cut short so its tail cannot pass for a start
    repeat (stp ? bt : (3 * bt) / 4) @(posedge core_clk);
    rxd_in <= 1'b1;
    repeat (bt) @(posedge core_clk);
  endtask
  // Samples nb bits after the start at mid bit
  task automatic recv(input int bt, input int nb, output logic [9:0] v);
    v = '0;
    @(negedge txd_out);
    repeat (bt / 2) @(posedge core_clk);
    for (int i = 0; i < nb; i++)
    begin
      repeat (bt) @(posedge core_clk);
      v[i] = txd_out;
    end
  endtask
endmodule

// >>> tb.sv
// Testbench of the USART core: bus tasks, FIFO, frame and pin clock checks.
// Assumes usc_chk.sv and usc_peer.sv are compiled before it.
`timescale 1ns/1ps
`include "usc_map.svh"
module tb
  import usc_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  usc_axi_req_type req = '0;
  usc_axi_rsp_type axi_rsp;
  logic rxd_in;
  logic txd_out;
  logic pin_o;
  logic pin_oe;
  logic irq_rx;
  logic irq_tx;
  logic irq_de;
  logic pin_i = 1'b0;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] d;
  logic [1:0] r;
  logic [9:0] v;
  time t1;
  // Reset values of status A, ctrl B, ctrl C, divisor and pin direction
  logic [7:0] ra [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] re [6] = '{32'h20, 32'h0, 32'h6, 32'h0, 32'h0, 32'h0};
  usc_core usc_core_i (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1), .axi_req(req),
    .axi_rsp(axi_rsp), .rxd_in(rxd_in), .txd_out(txd_out), .sync_clock_pin_i(pin_i),
    .sync_clock_pin_o(pin_o), .sync_clock_pin_oe(pin_oe), .irq_rx_complete(irq_rx),
    .irq_tx_complete(irq_tx), .irq_data_empty(irq_de));
  usc_peer usc_peer_i (.core_clk(core_clk), .txd_out(txd_out), .rxd_in(rxd_in));
  always #50 core_clk = ~core_clk;
  // Hang guard well above the few thousand cycles the tests take
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    req.awaddr <= a;
    req.wdata <= wd;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (axi_rsp.awready)
        req.awvalid <= 1'b0;
      if (axi_rsp.wready)
        req.wvalid <= 1'b0;
    end
    while (req.awvalid || req.wvalid);
    while (!axi_rsp.bvalid)
      @(posedge core_clk);
    // Late ready lets the answer be seen standing
    req.bready <= 1'b1;
    @(posedge core_clk);
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] rdat, output logic [1:0] rr);
    @(posedge core_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do
      @(posedge core_clk);
    while (!axi_rsp.arready);
    req.arvalid <= 1'b0;
    do
      @(posedge core_clk);
    while (!axi_rsp.rvalid);
    req.rready <= 1'b1;
    @(posedge core_clk);
    rdat = axi_rsp.rdata;
    rr = axi_rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d, r);
    chk(d, exp);
  endtask
  // Counts pin clock changes over 40 cycles
  task automatic toggles(input int exp);
    int n;
    logic p;
    n = 0;
    p = pin_o;
    repeat (40)
    begin
      @(posedge core_clk);
      n += int'(pin_o !== p);
      p = pin_o;
    end
    chk(n, exp);
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (ra[i]) rdc(ra[i], re[i]);
    rd(8'h1C, d, r);
    chk({30'h0, r}, {30'h0, `USC_RESP_SLVERR});
    // High half first; the low write reloads the counter with the divisor as it stood before that write
    wr(`USC_OFS_BDH, 32'hFF);
    rdc(`USC_OFS_BDH, 32'hF);
    wr(`USC_OFS_BDH, 32'h0);
    wr(`USC_OFS_BDL, 32'h1);
    wr(`USC_OFS_CSB, 32'hF8);
    // Three characters: two in the FIFO, the third held in the shifter
    for (int i = 1; i <= 3; i++) usc_peer_i.send(8'(8'h11 * i), 32, 1'b1);
    chk(irq_rx, 1'b1);
    chk(irq_de, 1'b1);
    rdc(`USC_OFS_CSA, 32'hA0);
    for (int i = 1; i <= 3; i++) rdc(`USC_OFS_DATA, 32'h11 * i);
    rdc(`USC_OFS_CSA, 32'h20);
    chk(irq_rx, 1'b0);
    // Fourth start while third is held: third lost, fourth flagged
    for (int i = 1; i <= 4; i++) usc_peer_i.send(8'(8'h40 + i), 32, 1'b1);
    rdc(`USC_OFS_DATA, 32'h41);
    rdc(`USC_OFS_DATA, 32'h42);
    rdc(`USC_OFS_CSA, 32'hA8);
    rdc(`USC_OFS_DATA, 32'h44);
    usc_peer_i.send(8'h5A, 32, 1'b0);
    rdc(`USC_OFS_CSA, 32'hB0);
    rdc(`USC_OFS_DATA, 32'h5A);
    rdc(`USC_OFS_CSA, 32'h20);
    // Even parity, two frames with the second buffered during the first
    wr(`USC_OFS_CSC, 32'h26);
    fork
      begin
        usc_peer_i.recv(32, 10, v);
        t1 = $time;
        chk(v, {1'b1, ^8'hA5, 8'hA5});
        usc_peer_i.recv(32, 10, v);
        chk(v, {1'b1, ^8'h3C, 8'h3C});
        chk(($time - t1) / 100, 11 * 32);
      end
      begin
        wr(`USC_OFS_DATA, 32'hA5);
        do
          rd(`USC_OFS_CSA, d, r);
        while (!d[5]);
        wr(`USC_OFS_DATA, 32'h3C);
      end
    join
    // Double speed, odd parity: half the bit time
    wr(`USC_OFS_CSA, 32'h02);
    wr(`USC_OFS_CSC, 32'h36);
    fork
      usc_peer_i.recv(16, 10, v);
      wr(`USC_OFS_DATA, 32'h5B);
    join
    chk(v, {1'b1, ~^8'h5B, 8'h5B});
    wr(`USC_OFS_CSA, 32'h0);
    // Sync master: device drives the pin, one change per baud tick
    wr(`USC_OFS_PDIR, 32'h1);
    wr(`USC_OFS_CSC, 32'h46);
    chk(pin_oe, 1'b1);
    toggles(20);
    chk(irq_tx, 1'b1);
    wr(`USC_OFS_BDL, 32'h3);
    toggles(10);
    // Slave: the transmitter waits for a rising pin edge before its start bit
    wr(`USC_OFS_PDIR, 32'h0);
    chk(pin_oe, 1'b0);
    wr(`USC_OFS_DATA, 32'h0);
    repeat (8) @(posedge core_clk);
    chk(txd_out, 1'b1);
    pin_i <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(txd_out, 1'b0);
    wr(`USC_OFS_CSC, 32'h06);
    chk(pin_oe, 1'b0);
    give_verdict();
  end
endmodule
